/* File: ircm_top.sv */
// ir carrier modulator: carrier count registers, direct latch, mark/space modulator
// assumes an avalon-mm master on clk_sys_in; clk_sys_in is the oscillator clock
//
// The Avalon-MM interface to the registers was chosen for this implementation.
`timescale 1ns/100ps
`include "ircm_defs.svh"

module ircm_top (
   // clock and reset
   input  wire logic        clk_sys_in,
   input  wire logic        sys_rst_in,
   // avalon-mm slave
   input  wire logic [7:0]  avs_address_in,
   input  wire logic        avs_read_in,
   input  wire logic        avs_write_in,
   input  wire logic [31:0] avs_writedata_in,
   input  wire logic [3:0]  avs_byteenable_in,
   output logic      [31:0] avs_readdata_out,
   output logic             avs_waitrequest_out,
   // emitter pin
   output logic             infrared_output_pin_out
);

   ircm_pkg::ircm_counts_s counts_reg;
   ircm_pkg::ircm_ctrl_s   ctrl_reg;
   ircm_pkg::ircm_state_e  state_reg;
   logic [11:0] mark_buffer_reg;
   logic [11:0] space_buffer_reg;
   logic [11:0] active_space_reg;
   logic [11:0] mod_cnt_reg;
   logic [2:0]  pre_reg;
   logic [7:0]  rd_value;
   logic [7:0]  wdata;
   logic [5:0]  idx;
   logic        ack_reg;
   logic        req;
   logic        wr_take;
   logic        output_polarity_reg;
   logic        latch_reg;
   logic        pend_fall_reg;
   logic        pend_fall_val_reg;
   logic        pend_rise_reg;
   logic        pend_rise_val_reg;
   logic        phase_reg;
   logic        gate_reg;
   logic        sel_reg;
   logic        pin_reg;
   logic [31:0] readdata_reg;
   logic        use_sec;
   logic        mod_clk_tick;
   logic        time_tick;
   logic        mod_tick;
   logic        carrier;
   logic        carrier_eff;
   logic        period_end;
   logic        space_match;
   logic        cycle_end;
   logic        restart;
   logic        gate_close;

   // bus handshake: one wait cycle, answer at the second edge
   assign req                 = avs_read_in || avs_write_in;
   assign avs_waitrequest_out = req && !ack_reg;
   assign avs_readdata_out    = readdata_reg;
   assign idx                 = avs_address_in[7:2];
   assign wdata               = avs_writedata_in[7:0];
   assign wr_take             = avs_write_in && ack_reg && avs_byteenable_in[0];

   always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         ack_reg <= 1'h0;
      end else begin
         ack_reg <= req && !ack_reg;
      end
   end

   // read mux, unmapped and unused bits read zero
   always_comb begin
      unique case (idx)
         `IRCM_IDX_PRI_HIGH: rd_value = {latch_reg, output_polarity_reg,
                                         counts_reg.pri_high};
         `IRCM_IDX_PRI_LOW:  rd_value = {latch_reg, 1'h0, counts_reg.pri_low};
         `IRCM_IDX_SEC_HIGH: rd_value = {2'h0, counts_reg.sec_high};
         `IRCM_IDX_SEC_LOW:  rd_value = {2'h0, counts_reg.sec_low};
         `IRCM_IDX_CTRL:     rd_value = {state_reg != ircm_pkg::ST_IDLE, ctrl_reg.half_rate_prescale,
                                         3'h0, ctrl_reg.baseband_select, ctrl_reg.mode, ctrl_reg.en};
         `IRCM_IDX_MOD_A:    rd_value = {space_buffer_reg[11:8], mark_buffer_reg[11:8]};
         `IRCM_IDX_MOD_B:    rd_value = mark_buffer_reg[7:0];
         `IRCM_IDX_MOD_C:    rd_value = space_buffer_reg[7:0];
         default:            rd_value = 8'h00;
      endcase
   end

   always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         readdata_reg <= 32'h0000_0000;
      end else if (avs_read_in && !ack_reg) begin
         readdata_reg <= {24'h00_0000, rd_value};
      end
   end

   // count fields keep their value through reset
   always_ff @(posedge clk_sys_in) begin
      if (wr_take) begin
         unique case (idx)
            `IRCM_IDX_PRI_HIGH: counts_reg.pri_high <= wdata[`IRCM_CNT_MSB:0];
            `IRCM_IDX_PRI_LOW:  counts_reg.pri_low  <= wdata[`IRCM_CNT_MSB:0];
            `IRCM_IDX_SEC_HIGH: counts_reg.sec_high <= wdata[`IRCM_CNT_MSB:0];
            `IRCM_IDX_SEC_LOW:  counts_reg.sec_low  <= wdata[`IRCM_CNT_MSB:0];
            default:            counts_reg <= counts_reg;
         endcase
      end
   end

   // polarity bit of the primary high register
   always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         output_polarity_reg <= 1'h0;
      end else if (wr_take && idx == `IRCM_IDX_PRI_HIGH) begin
         output_polarity_reg <= wdata[`IRCM_BIT_POL];
      end
   end

   // control register and modulator buffers
   always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         ctrl_reg         <= `IRCM_CTRL_RST;
         mark_buffer_reg  <= `IRCM_MOD_ZERO;
         space_buffer_reg <= `IRCM_MOD_ZERO;
      end else if (wr_take) begin
         unique case (idx)
            `IRCM_IDX_CTRL: begin
               ctrl_reg.en   <= wdata[`IRCM_BIT_EN];
               ctrl_reg.mode <= wdata[`IRCM_BIT_MODE];
               ctrl_reg.baseband_select <= wdata[`IRCM_BIT_BASEBAND_SELECT];
               ctrl_reg.half_rate_prescale <= wdata[`IRCM_BIT_HALF_RATE_PRESCALE];
            end
            `IRCM_IDX_MOD_A: begin
               mark_buffer_reg[11:8]  <= wdata[3:0];
               space_buffer_reg[11:8] <= wdata[7:4];
            end
            `IRCM_IDX_MOD_B: mark_buffer_reg[7:0]  <= wdata;
            `IRCM_IDX_MOD_C: space_buffer_reg[7:0] <= wdata;
            default: ctrl_reg <= ctrl_reg;
         endcase
      end
   end

   // bus clock phase, oscillator divided by two
   always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         phase_reg <= `IRCM_PH_FALL;
      end else begin
         phase_reg <= !phase_reg;
      end
   end

   // latch writes wait for their bus clock edge; a new write replaces a pending one
   always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         pend_fall_reg     <= 1'h0;
         pend_fall_val_reg <= 1'h0;
         pend_rise_reg     <= 1'h0;
         pend_rise_val_reg <= 1'h0;
      end else begin
         if (wr_take && idx == `IRCM_IDX_PRI_HIGH) begin
            pend_fall_reg     <= 1'h1;
            pend_fall_val_reg <= wdata[`IRCM_BIT_LATCH];
         end else if (phase_reg == `IRCM_PH_FALL) begin
            pend_fall_reg <= 1'h0;
         end
         if (wr_take && idx == `IRCM_IDX_PRI_LOW) begin
            pend_rise_reg     <= 1'h1;
            pend_rise_val_reg <= wdata[`IRCM_BIT_LATCH];
         end else if (phase_reg == `IRCM_PH_RISE) begin
            pend_rise_reg <= 1'h0;
         end
      end
   end

   always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         latch_reg <= 1'h0;
      end else if (pend_fall_reg && phase_reg == `IRCM_PH_FALL) begin
         latch_reg <= pend_fall_val_reg;
      end else if (pend_rise_reg && phase_reg == `IRCM_PH_RISE) begin
         latch_reg <= pend_rise_val_reg;
      end
   end

   // module clock enable and modulator time baseband_select
   assign mod_clk_tick = ctrl_reg.half_rate_prescale ? phase_reg : 1'h1;
   assign time_tick    = mod_clk_tick && pre_reg == `IRCM_TIME_DIV;
   assign mod_tick     = ctrl_reg.mode ? period_end : time_tick;

   always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         pre_reg <= 3'h0;
      end else if (mod_clk_tick) begin
         pre_reg <= pre_reg + 3'h1;
      end
   end

   // carrier generator
   assign use_sec     = ctrl_reg.mode && sel_reg;
   assign carrier_eff = ctrl_reg.baseband_select ? 1'h1 : carrier;
   assign restart     = (state_reg == ircm_pkg::ST_IDLE && ctrl_reg.en)
                        || (cycle_end && !gate_reg);

   ircm_carrier u_carrier (
      .clk_sys_in     (clk_sys_in),
      .sys_rst_in     (sys_rst_in),
      .tick_in        (mod_clk_tick),
      .run_in         (ctrl_reg.en && !ctrl_reg.baseband_select),
      .restart_in     (restart),
      .use_sec_in     (use_sec),
      .counts_in      (counts_reg),
      .carrier_out    (carrier),
      .period_end_out (period_end)
   );

   // modulator counter and state
   assign space_match = state_reg == ircm_pkg::ST_SPACE
                        && ~mod_cnt_reg == active_space_reg;
   assign cycle_end   = space_match && ctrl_reg.en;
   assign gate_close  = state_reg == ircm_pkg::ST_SPACE && !space_match
                        && (ctrl_reg.baseband_select || !carrier);

   always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         state_reg        <= ircm_pkg::ST_IDLE;
         mod_cnt_reg      <= `IRCM_MOD_ZERO;
         active_space_reg <= `IRCM_MOD_ZERO;
      end else if (!ctrl_reg.en) begin
         state_reg <= ircm_pkg::ST_IDLE;
      end else begin
         unique case (state_reg)
            ircm_pkg::ST_IDLE: begin
               state_reg        <= ircm_pkg::ST_MARK;
               mod_cnt_reg      <= mark_buffer_reg;
               active_space_reg <= space_buffer_reg;
            end
            ircm_pkg::ST_MARK: begin
               if (mod_tick) begin
                  if (mod_cnt_reg == `IRCM_MOD_ZERO) begin
                     state_reg <= ircm_pkg::ST_SPACE;
                  end
                  mod_cnt_reg <= mod_cnt_reg - `IRCM_MOD_ONE;
               end
            end
            ircm_pkg::ST_SPACE: begin
               if (space_match) begin
                  state_reg        <= ircm_pkg::ST_MARK;
                  mod_cnt_reg      <= mark_buffer_reg;
                  active_space_reg <= space_buffer_reg;
               end else if (mod_tick) begin
                  mod_cnt_reg <= mod_cnt_reg - `IRCM_MOD_ONE;
               end
            end
         endcase
      end
   end

   // gate and count set selection
   always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         gate_reg <= 1'h0;
         sel_reg  <= 1'h0;
      end else if (!ctrl_reg.en) begin
         gate_reg <= 1'h0;
         sel_reg  <= 1'h0;
      end else begin
         if (state_reg == ircm_pkg::ST_IDLE || cycle_end) begin
            gate_reg <= 1'h1;
         end else if (gate_close) begin
            gate_reg <= 1'h0;
         end
         if (cycle_end && ctrl_reg.mode) begin
            sel_reg <= !sel_reg;
         end
      end
   end

   // pin: modulator output when enabled, latch otherwise
   always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         pin_reg <= 1'h0;
      end else if (ctrl_reg.en) begin
         pin_reg <= (gate_reg && carrier_eff) ^ output_polarity_reg;
      end else begin
         pin_reg <= latch_reg;
      end
   end

   assign infrared_output_pin_out = pin_reg;

   // checks
   default clocking cb @(posedge clk_sys_in);
   endclocking
   default disable iff (sys_rst_in);

   sequence s_eight_ticks;
      (!time_tick) [*7] ##1 time_tick;
   endsequence

   sequence s_underflow;
      state_reg == ircm_pkg::ST_MARK && mod_tick && mod_cnt_reg == `IRCM_MOD_ZERO;
   endsequence

   chk_pin_follows_latch: assert property (
      !ctrl_reg.en |=> infrared_output_pin_out == $past(latch_reg))
      else $error("pin does not follow latch while disabled");

   chk_time_primary_only: assert property (
      !ctrl_reg.mode |-> !use_sec)
      else $error("secondary counts used in time mode");

   chk_fsk_set_toggle: assert property (
      (ctrl_reg.mode && cycle_end) |=> sel_reg != $past(sel_reg))
      else $error("count set not switched at period end");

   chk_latch_read: assert property (
      (avs_read_in && !ack_reg && idx == `IRCM_IDX_PRI_LOW)
      |=> readdata_reg[`IRCM_BIT_LATCH] == $past(latch_reg))
      else $error("latch read back wrong");

   chk_latch_fall_edge: assert property (
      (wr_take && idx == `IRCM_IDX_PRI_HIGH) ##1 (phase_reg == `IRCM_PH_FALL)
      |=> latch_reg == $past(pend_fall_val_reg))
      else $error("latch not updated on falling bus edge");

   chk_mark_underflow: assert property (
      s_underflow ##1 ctrl_reg.en
      |-> state_reg == ircm_pkg::ST_SPACE && mod_cnt_reg == `IRCM_MOD_FULL)
      else $error("underflow did not enter space");

   chk_zero_space: assert property (
      (state_reg == ircm_pkg::ST_SPACE && active_space_reg == `IRCM_MOD_ZERO && ctrl_reg.en)
      |=> state_reg == ircm_pkg::ST_MARK)
      else $error("zero space produced a space period");

   chk_space_reload: assert property (
      cycle_end |=> mod_cnt_reg == $past(mark_buffer_reg)
                    && active_space_reg == $past(space_buffer_reg))
      else $error("reload at cycle end wrong");

   chk_idle_disabled: assert property (
      !ctrl_reg.en |=> state_reg == ircm_pkg::ST_IDLE)
      else $error("modulator runs while disabled");

   chk_prescale_eight: assert property (
      (time_tick && !ctrl_reg.half_rate_prescale && ctrl_reg.en) |=> s_eight_ticks)
      else $error("time baseband_select not divided by eight");

   chk_gate_closes_low: assert property (
      $fell(gate_reg) && ctrl_reg.en && !ctrl_reg.baseband_select |-> !$past(carrier_eff))
      else $error("gate closed while carrier high");

   chk_baseband_level: assert property (
      (ctrl_reg.en && ctrl_reg.baseband_select && !output_polarity_reg)
      |=> infrared_output_pin_out == $past(gate_reg))
      else $error("baseband pin does not match gate");

endmodule

/* File: ircm_defs.svh */
// register indices, field positions, reset values and counts of the ir carrier modulator
// assumes it is included by bare name from each design file that needs it
`ifndef IRCM_DEFS_SVH
`define IRCM_DEFS_SVH

// register indices, byte address is four times the index
`define IRCM_IDX_PRI_HIGH 6'h10
`define IRCM_IDX_PRI_LOW  6'h11
`define IRCM_IDX_SEC_HIGH 6'h12
`define IRCM_IDX_SEC_LOW  6'h13
`define IRCM_IDX_CTRL     6'h14
`define IRCM_IDX_MOD_A    6'h15
`define IRCM_IDX_MOD_B    6'h16
`define IRCM_IDX_MOD_C    6'h17

// fields of the carrier count registers
`define IRCM_BIT_LATCH    7
`define IRCM_BIT_POL      6
`define IRCM_CNT_MSB      5

// fields of the control register
`define IRCM_BIT_EN       0
`define IRCM_BIT_MODE     1
`define IRCM_BIT_BASEBAND_SELECT     2
`define IRCM_BIT_HALF_RATE_PRESCALE     6
`define IRCM_BIT_ACTIVE   7

// reset values and counts
`define IRCM_CTRL_RST     4'h0
`define IRCM_TIME_DIV     3'h7
`define IRCM_CNT_ONE      6'h01
`define IRCM_CNT_ZERO     6'h00
`define IRCM_MOD_ONE      12'h001
`define IRCM_MOD_ZERO     12'h000
`define IRCM_MOD_FULL     12'hFFF
`define IRCM_PH_FALL      1'h0
`define IRCM_PH_RISE      1'h1

`endif

/* File: ircm_pkg.sv */
// types shared by the ir carrier modulator files
// assumes the constants header is compiled alongside
package ircm_pkg;

   typedef struct packed {
      logic [5:0] pri_high;
      logic [5:0] pri_low;
      logic [5:0] sec_high;
      logic [5:0] sec_low;
   } ircm_counts_s;

   typedef struct packed {
      logic half_rate_prescale;
      logic baseband_select;
      logic mode;
      logic en;
   } ircm_ctrl_s;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'b001,
      ST_MARK  = 3'b010,
      ST_SPACE = 3'b100
   } ircm_state_e;

endpackage

/* File: ircm_carrier.sv */
// carrier generator: 6-bit up counter toggling between high and low counts
// assumes tick_in is the module clock enable and counts are stable while running
`timescale 1ns/100ps
`include "ircm_defs.svh"

module ircm_carrier (
   // clock and reset
   input  wire logic                  clk_sys_in,
   input  wire logic                  sys_rst_in,
   // control
   input  wire logic                  tick_in,
   input  wire logic                  run_in,
   input  wire logic                  restart_in,
   input  wire logic                  use_sec_in,
   input  wire ircm_pkg::ircm_counts_s counts_in,
   // carrier
   output logic                       carrier_out,
   output logic                       period_end_out
);

   logic [5:0] cnt_reg;
   logic [5:0] cnt_next;
   logic [5:0] high_cnt;
   logic [5:0] low_cnt;
   logic       level_reg;

   // count set choice
   assign high_cnt = use_sec_in ? counts_in.sec_high : counts_in.pri_high;
   assign low_cnt  = use_sec_in ? counts_in.sec_low  : counts_in.pri_low;
   assign cnt_next = cnt_reg + `IRCM_CNT_ONE;

   always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         cnt_reg   <= `IRCM_CNT_ZERO;
         level_reg <= 1'h1;
      end else if (!run_in || restart_in) begin
         cnt_reg   <= `IRCM_CNT_ZERO;
         level_reg <= 1'h1;
      end else if (tick_in) begin
         if (level_reg && cnt_next == high_cnt) begin
            cnt_reg   <= `IRCM_CNT_ZERO;
            level_reg <= 1'h0;
         end else if (!level_reg && cnt_next == low_cnt) begin
            cnt_reg   <= `IRCM_CNT_ZERO;
            level_reg <= 1'h1;
         end else begin
            cnt_reg <= cnt_next;
         end
      end
   end

   assign carrier_out    = level_reg;
   assign period_end_out = run_in && !restart_in && tick_in && !level_reg
                           && cnt_next == low_cnt;

endmodule

/* File: ircm_ir_emitter.sv */
// infrared emitter model: measures high and low run lengths on the pin
// assumes the pin is sampled on the rising edge of clk_sys_in
`timescale 1ns/100ps

module ircm_ir_emitter (
   // clock and reset
   input  wire logic        clk_sys_in,
   input  wire logic        sys_rst_in,
   // control and pin
   input  wire logic        clear_in,
   input  wire logic        infrared_output_pin_in,
   // measurements
   output logic      [15:0] high_run_out,
   output logic      [15:0] low_run_out,
   output logic      [63:0] seen_high_out
);
   logic        prev_reg;
   logic [15:0] cnt_reg;
   logic        valid_reg;

   // a run ends at the edge where the pin changes level
   always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         prev_reg      <= 1'b0;
         valid_reg     <= 1'b0;
         cnt_reg       <= 16'h0001;
         high_run_out  <= 16'h0000;
         low_run_out   <= 16'h0000;
         seen_high_out <= 64'h0;
      end else if (clear_in) begin
         prev_reg      <= infrared_output_pin_in;
         valid_reg     <= 1'b0;
         cnt_reg       <= 16'h0001;
         seen_high_out <= 64'h0;
      end else if (infrared_output_pin_in != prev_reg) begin
         prev_reg  <= infrared_output_pin_in;
         cnt_reg   <= 16'h0001;
         valid_reg <= 1'b1;
         // a run cut short by a clear is partial and is not reported
         if (valid_reg && prev_reg) begin
            high_run_out <= cnt_reg;
            if (cnt_reg < 16'h0040) begin
               seen_high_out[cnt_reg[5:0]] <= 1'b1;
            end
         end else if (valid_reg) begin
            low_run_out <= cnt_reg;
         end
      end else begin
         cnt_reg <= cnt_reg + 16'h0001;
      end
   end
endmodule

/* File: tb_top.sv */
// testbench of the ir carrier modulator: register access and pin timing
// assumes ircm_top answers every avalon request after one wait cycle
`timescale 1ns/100ps

module tb_top;
   logic        clk_sys_in, sys_rst_in, avs_read_in, avs_write_in, clear;
   logic [7:0]  avs_address_in;
   logic [31:0] avs_writedata_in, avs_readdata_out, q;
   logic [3:0]  avs_byteenable_in;
   logic        avs_waitrequest_out, infrared_output_pin_out;
   logic [15:0] high_run, low_run;
   logic [63:0] seen_high;
   int          n_mismatch = 0;
   int          samples_checked = 0;

   ircm_top DUT (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in),
      .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
      .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
      .avs_byteenable_in(avs_byteenable_in), .avs_readdata_out(avs_readdata_out),
      .avs_waitrequest_out(avs_waitrequest_out),
      .infrared_output_pin_out(infrared_output_pin_out));

   ircm_ir_emitter emitter (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in),
      .clear_in(clear), .infrared_output_pin_in(infrared_output_pin_out),
      .high_run_out(high_run), .low_run_out(low_run), .seen_high_out(seen_high));

   always #5 clk_sys_in = ~clk_sys_in;

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         $display("[ERR] %s expected %h seen %h", what, exp, got);
         n_mismatch++;
      end
   endtask

   // one avalon transfer, held until waitrequest is sampled low
   task automatic xfer(input logic wr, input logic [5:0] idx, input logic [7:0] d,
                       input logic [3:0] be, output logic [31:0] rdata);
      int n;
      n = 0;
      @(posedge clk_sys_in);
      avs_address_in    <= {idx, 2'h0};
      avs_writedata_in  <= {24'h000000, d};
      avs_byteenable_in <= be;
      avs_read_in       <= !wr;
      avs_write_in      <= wr;
      do begin
         @(posedge clk_sys_in);
         n++;
      end while (avs_waitrequest_out !== 1'b0 && n < 40);
      if (n >= 40) begin
         $display("[ERR] waitrequest expected 0 seen 1");
         n_mismatch++;
      end
      rdata = avs_readdata_out;
      avs_read_in  <= 1'b0;
      avs_write_in <= 1'b0;
   endtask

   task automatic wr(input logic [5:0] idx, input logic [7:0] d);
      logic [31:0] r;
      xfer(1'b1, idx, d, 4'hF, r);
   endtask

   task automatic rd(input logic [5:0] idx, input logic [31:0] mask, input logic [31:0] exp);
      logic [31:0] r;
      xfer(1'b0, idx, 8'h00, 4'hF, r);
      check($sformatf("register %h", idx), exp, r & mask);
   endtask

   task automatic wait_pin(input logic exp);
      int n;
      n = 0;
      while (infrared_output_pin_out !== exp && n < 4) begin
         @(posedge clk_sys_in);
         n++;
      end
      check("pin", {31'h0, exp}, {31'h0, infrared_output_pin_out});
   endtask

   // load mark and space buffers while stopped, then enable and measure
   task automatic run(input logic [7:0] ctrl, input logic [11:0] m, input logic [11:0] s);
      wr(6'h14, 8'h00);
      wr(6'h15, {s[11:8], m[11:8]});
      wr(6'h16, m[7:0]);
      wr(6'h17, s[7:0]);
      wr(6'h14, ctrl);
      repeat (300) @(posedge clk_sys_in);
      clear <= 1'b1;
      @(posedge clk_sys_in);
      clear <= 1'b0;
      repeat (600) @(posedge clk_sys_in);
   endtask

   initial begin
      clk_sys_in = 1'b0;
      sys_rst_in = 1'b1;
      avs_read_in = 1'b0;
      avs_write_in = 1'b0;
      avs_address_in = 8'h00;
      avs_writedata_in = 32'h0;
      avs_byteenable_in = 4'h0;
      clear = 1'b0;
      repeat (16) @(posedge clk_sys_in);
      sys_rst_in <= 1'b0;
      @(posedge clk_sys_in);
      check("pin", 32'h0, {31'h0, infrared_output_pin_out});
      for (int i = 0; i < 4; i++) begin
         rd(6'h10 + i[5:0], 32'hFFFFFFC0, 32'h0);
      end
      rd(6'h00, 32'hFFFFFFFF, 32'h0);
      wr(6'h12, 8'hFF);
      rd(6'h12, 32'hFFFFFFFF, 32'h3F);
      xfer(1'b1, 6'h12, 8'h01, 4'h0, q);
      rd(6'h12, 32'hFFFFFFFF, 32'h3F);
      wr(6'h13, 8'hC4);
      rd(6'h13, 32'hFFFFFFFF, 32'h04);
      wr(6'h12, 8'h04);
      wr(6'h10, 8'h82);
      wait_pin(1'b1);
      rd(6'h10, 32'hFFFFFFFF, 32'h82);
      rd(6'h11, 32'h80, 32'h80);
      wr(6'h11, 8'h03);
      wait_pin(1'b0);
      rd(6'h10, 32'hFFFFFFFF, 32'h02);
      rd(6'h11, 32'hFFFFFFFF, 32'h03);
      wr(6'h11, 8'h83);
      wait_pin(1'b1);
      sys_rst_in <= 1'b1;
      repeat (16) @(posedge clk_sys_in);
      sys_rst_in <= 1'b0;
      rd(6'h10, 32'hFFFFFFFF, 32'h02);
      rd(6'h11, 32'hFFFFFFFF, 32'h03);
      rd(6'h13, 32'hFFFFFFFF, 32'h04);
      // all four counts are nonzero before any enable
      run(8'h05, 12'h003, 12'h002);
      check("mark run", 32'h1, {31'h0, high_run >= 16'd31 && high_run <= 16'd33});
      check("space run", 32'h1, {31'h0, low_run >= 16'd16 && low_run <= 16'd18});
      run(8'h01, 12'h0FF, 12'h000);
      check("high runs", 32'h4, seen_high[31:0]);
      check("low run", 32'h3, {16'h0, low_run});
      rd(6'h14, 32'hFF, 32'h81);
      run(8'h03, 12'h001, 12'h000);
      check("high runs", 32'h14, seen_high[31:0]);
      run(8'h41, 12'h0FF, 12'h000);
      check("high runs", 32'h10, seen_high[31:0]);
      check("low run", 32'h6, {16'h0, low_run});
      // gated carrier with a space: every burst keeps its full high time
      run(8'h01, 12'h003, 12'h002);
      check("high runs", 32'h4, seen_high[31:0]);
      wr(6'h10, 8'h82);
      wr(6'h14, 8'h00);
      repeat (2) @(posedge clk_sys_in);
      check("pin", 32'h1, {31'h0, infrared_output_pin_out});
      rd(6'h14, 32'hFF, 32'h00);
      tally_and_finish;
   end

   initial begin
      repeat (20000) @(posedge clk_sys_in);
      $display("[ERR] run expected done seen timeout");
      n_mismatch++;
      tally_and_finish;
   end
endmodule
